/* hw/ppfs_params.svh */
// Register offsets, field positions, reset values and mode codes of the pin function block
`ifndef PPFS_PARAMS_SVH
`define PPFS_PARAMS_SVH
`define PPFS_OFS_PORTB_CTRL 12'h000
`define PPFS_OFS_PORTE_CTRL2 12'h004
`define PPFS_OFS_STATUS 12'h008
`define PPFS_PB2_LSB 8
`define PPFS_PB1_LSB 4
`define PPFS_PB0_LSB 0
`define PPFS_PORTE_LINE_21_LSB 4
`define PPFS_PORTE_LINE_20_LSB 0
`define PPFS_PORTB_WMASK 16'h0777
`define PPFS_PORTE_WMASK 16'h0033
`define PPFS_PORTB_RST 16'h0000
`define PPFS_PORTE_RST 16'h0000
`define PPFS_PB_PORT 3'h0
`define PPFS_PB2_IRQ 3'h1
`define PPFS_PB2_OEREQ 3'h2
`define PPFS_PB_ADDR 3'h1
`define PPFS_PB_CAPW 3'h3
`define PPFS_PE_PORT 2'h0
`define PPFS_PE_TIMER 2'h1
`endif

/* hw/ppfs_pkg.sv */
// Types shared by the pin function select block
package ppfs_pkg;
  typedef enum logic [1:0] {PPFS_SEL_PORT, PPFS_SEL_PERIPH_IN, PPFS_SEL_PERIPH_OUT,
    PPFS_SEL_PERIPH_IO} ppfs_sel_t;
  typedef logic [15:0] ppfs_word_t;
endpackage

/* hw/ppfs_pad_if.sv */
// Interface carrying one pin's drive, enable and resolved function between modules
`timescale 1ns/1ps
interface ppfs_pad_if;
  import ppfs_pkg::*;
  ppfs_sel_t sel;
  logic port_out;
  logic port_dir;
  logic periph_out;
  logic periph_oe;
  logic pin_out;
  logic pin_oe;
  modport ctrl (output sel, output port_out, output port_dir, output periph_out,
    output periph_oe, input pin_out, input pin_oe);
  modport pad (input sel, input port_out, input port_dir, input periph_out,
    input periph_oe, output pin_out, output pin_oe);
endinterface

/* hw/ppfs_pad_mux.sv */
// Per-pin output driver and direction selection
`timescale 1ns/1ps
module ppfs_pad_mux (
  // Pin control bundle
  ppfs_pad_if.pad p
);
  import ppfs_pkg::*;
  wire use_periph;
  // Peripheral drives the pin when a peripheral output or I/O is chosen
  assign use_periph = (p.sel == PPFS_SEL_PERIPH_OUT) || (p.sel == PPFS_SEL_PERIPH_IO);
  assign p.pin_out = use_periph ? p.periph_out : p.port_out;
  assign p.pin_oe = use_periph ? p.periph_oe : ((p.sel == PPFS_SEL_PORT) & p.port_dir);
endmodule

/* hw/ppfs_in_merge.sv */
// Merges a pin-sourced input function over several pins by OR or AND
`timescale 1ns/1ps
module ppfs_in_merge #(
  parameter int N = 2,
  parameter bit AND_TYPE = 1'b0
) (
  // Candidate pins and their selection
  input wire logic [N-1:0] pin_val,
  input wire logic [N-1:0] pin_sel,
  // Merged signal
  output logic merged
);
  wire [N-1:0] terms;
  genvar i;
  // Unselected pins contribute the neutral value
  for (i = 0; i < N; i++) begin : g_term
    assign terms[i] = pin_sel[i] ? pin_val[i] : AND_TYPE;
  end
  // AND type for interrupts and enables, OR type for timer inputs
  assign merged = AND_TYPE ? &terms : |terms;
endmodule

/* hw/ppfs_top.sv */
// Pin function select for port B lines 2..0 and port E lines 21..20, with APB registers
// Notes on behaviour
// - port B line 2 field: 000 port, 001 interrupt 0 input, 010 output-enable input.
// - port B line 1 field: 000 port, 001 address bit 17 out, 011 capture W.
// - port B line 0 field: 000 port, 001 address bit 16 out, 011 secondary capture W.
// - port B control bits 7 and 3 read zero; write zero.
// - low bit of line 1 and 0 fields resets to 1 in ROM-less extension mode.
// - address outputs act only in external-extension modes.
// - port E line 21 field: 00 port, 01 secondary timer channel 4 D.
// - port E line 20 field: 00 port, 01 secondary timer channel 4 C.
// - port E control 2 bits 15..6 and 3..2 read zero.
// - one input function on several pins merges through OR or AND.
`timescale 1ns/1ps
`include "ppfs_params.svh"
module ppfs_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip operating mode straps
  input wire logic mode_ext_rom_off,
  input wire logic mode_ext,
  // Port data and direction registers, five lines: 0..2 port B, 3 line 20, 4 line 21
  input wire logic [4:0] port_data,
  input wire logic [4:0] port_dir,
  // Pin pads
  input wire logic [4:0] pad_in,
  output logic [4:0] pad_out,
  output logic [4:0] pad_oe,
  // Synchronised pin levels back to the port
  output logic [4:0] port_pin_level,
  // Bus controller address lines
  input wire logic address_bit_17_out,
  input wire logic address_bit_16_out,
  // Merged inputs toward peripherals, with other pins carrying the same function
  input wire logic external_interrupt_0_in_other_pins,
  input wire logic oereq0_other_pins,
  input wire logic capw_other_pins,
  input wire logic capws_other_pins,
  input wire logic ch4d_other_pins,
  input wire logic ch4c_other_pins,
  output logic external_interrupt_0_in,
  output logic output_enable_request_0_in,
  output logic timer_capture_w_in,
  output logic secondary_timer_capture_w_in,
  output logic secondary_timer_ch4_d_in,
  output logic secondary_timer_ch4_c_in,
  // Secondary timer channel 4 C and D drive
  input wire logic secondary_timer_ch4_d_out,
  input wire logic secondary_timer_ch4_d_oe,
  input wire logic secondary_timer_ch4_c_out,
  input wire logic secondary_timer_ch4_c_oe
);
  import ppfs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Registers and strap capture
  ppfs_word_t portb_ctrl_reg, portb_ctrl_next;
  ppfs_word_t port_e_high_function_control_2_reg, porte_ctrl_next;
  logic strap_done_reg;
  logic [4:0] pad_meta_reg, pad_sync_reg;
  logic [1:0] ext_meta_reg, ext_sync_reg;

  wire apb_wr = psel & penable & pwrite;
  wire hit_pb = paddr == `PPFS_OFS_PORTB_CTRL;
  wire hit_pe = paddr == `PPFS_OFS_PORTE_CTRL2;
  wire hit_st = paddr == `PPFS_OFS_STATUS;
  wire hit_any = hit_pb | hit_pe | hit_st;
  // Either extension mode enables the address outputs
  wire ext_ok = ext_sync_reg[1] | ext_sync_reg[0];

  // Only documented bits are writable, reserved bits stay zero
  assign portb_ctrl_next = (apb_wr & hit_pb) ? (pwdata[15:0] & `PPFS_PORTB_WMASK)
                                             : portb_ctrl_reg;
  assign porte_ctrl_next = (apb_wr & hit_pe) ? (pwdata[15:0] & `PPFS_PORTE_WMASK)
                                             : port_e_high_function_control_2_reg;

  // Register storage, reset to general port I/O; in ROM-less extension mode lines 1 and 0 start as address outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      portb_ctrl_reg <= `PPFS_PORTB_RST;
      port_e_high_function_control_2_reg <= `PPFS_PORTE_RST;
    end else if (!strap_done_reg) begin
      // First edge after release loads the mode-dependent low bits
      portb_ctrl_reg <= `PPFS_PORTB_RST | ({15'h0000, ext_sync_reg[1]} << `PPFS_PB1_LSB)
                        | ({15'h0000, ext_sync_reg[1]} << `PPFS_PB0_LSB);
    end else begin
      portb_ctrl_reg <= portb_ctrl_next;
      port_e_high_function_control_2_reg <= porte_ctrl_next;
    end
  end

  // Strap capture flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_reg <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
    end
  end

  // Two-stage synchronisers for the pads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_meta_reg <= 5'h00;
      pad_sync_reg <= 5'h00;
    end else begin
      pad_meta_reg <= pad_in;
      pad_sync_reg <= pad_meta_reg;
    end
  end

  // Strap synchronisers run through reset, so the strap is settled when reset ends
  // Reset must last at least two clock edges for the strap load to be valid
  always_ff @(posedge pclk) begin
    ext_meta_reg <= {mode_ext_rom_off, mode_ext};
    ext_sync_reg <= ext_meta_reg;
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB read path; zero-wait, unmapped addresses answer with pslverr
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  wire [31:0] rd_word = hit_pb ? {16'h0000, portb_ctrl_reg}
                      : hit_pe ? {16'h0000, port_e_high_function_control_2_reg}
                      : hit_st ? {30'h0, ext_sync_reg[1], ext_ok} : 32'h0;
  logic [31:0] prdata_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else begin
      prdata_reg <= (psel & ~penable & ~pwrite) ? rd_word : prdata_reg;
    end
  end
  assign prdata = prdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Field decode
  function automatic ppfs_sel_t pb_decode(input logic [2:0] code, input logic is_line2,
                                          input logic ext_ok);
    ppfs_sel_t s;
    s = PPFS_SEL_PORT;
    if (is_line2) begin
      if (code == `PPFS_PB2_IRQ || code == `PPFS_PB2_OEREQ) s = PPFS_SEL_PERIPH_IN;
    end else begin
      if (code == `PPFS_PB_ADDR && ext_ok) s = PPFS_SEL_PERIPH_OUT;
      else if (code == `PPFS_PB_ADDR) s = PPFS_SEL_PERIPH_IN;
      else if (code == `PPFS_PB_CAPW) s = PPFS_SEL_PERIPH_IN;
    end
    return s;
  endfunction

  wire [2:0] pb2_code = portb_ctrl_reg[`PPFS_PB2_LSB +: 3];
  wire [2:0] pb1_code = portb_ctrl_reg[`PPFS_PB1_LSB +: 3];
  wire [2:0] pb0_code = portb_ctrl_reg[`PPFS_PB0_LSB +: 3];
  wire [1:0] porte_line_21_code = port_e_high_function_control_2_reg[`PPFS_PORTE_LINE_21_LSB +: 2];
  wire [1:0] porte_line_20_code = port_e_high_function_control_2_reg[`PPFS_PORTE_LINE_20_LSB +: 2];

  // Line 2: interrupt 0 or output-enable request input
  wire pb2_irq = pb2_code == `PPFS_PB2_IRQ;
  wire pb2_oe = pb2_code == `PPFS_PB2_OEREQ;
  // Lines 1 and 0: address outputs only in extension modes
  wire pb1_capw = pb1_code == `PPFS_PB_CAPW;
  wire pb0_capw = pb0_code == `PPFS_PB_CAPW;
  wire pb1_addr = (pb1_code == `PPFS_PB_ADDR) & ext_ok;
  wire pb0_addr = (pb0_code == `PPFS_PB_ADDR) & ext_ok;
  // Port E timer channel selections
  wire porte_line_21_tmr = porte_line_21_code == `PPFS_PE_TIMER;
  wire porte_line_20_tmr = porte_line_20_code == `PPFS_PE_TIMER;

  //////////////////////////////////////////////////////////////////////////////
  // Pad muxes
  ppfs_pad_if pads [5] ();
  wire [4:0] per_out = {secondary_timer_ch4_d_out, secondary_timer_ch4_c_out, 1'b0,
                        address_bit_17_out, address_bit_16_out};
  wire [4:0] per_oe = {secondary_timer_ch4_d_oe, secondary_timer_ch4_c_oe, 1'b0,
                       pb1_addr, pb0_addr};
  wire [9:0] sel_bits;
  assign sel_bits[1:0] = pb_decode(pb0_code, 1'b0, ext_ok);
  assign sel_bits[3:2] = pb_decode(pb1_code, 1'b0, ext_ok);
  assign sel_bits[5:4] = pb_decode(pb2_code, 1'b1, ext_ok);
  assign sel_bits[7:6] = porte_line_20_tmr ? PPFS_SEL_PERIPH_IO : PPFS_SEL_PORT;
  assign sel_bits[9:8] = porte_line_21_tmr ? PPFS_SEL_PERIPH_IO : PPFS_SEL_PORT;

  genvar k;
  for (k = 0; k < 5; k++) begin : g_pad
    assign pads[k].sel = ppfs_sel_t'(sel_bits[2*k +: 2]);
    assign pads[k].port_out = port_data[k];
    assign pads[k].port_dir = port_dir[k];
    assign pads[k].periph_out = per_out[k];
    assign pads[k].periph_oe = per_oe[k];
    ppfs_pad_mux u_mux (.p(pads[k].pad));
    // Drive and direction from port or peripheral
    assign pad_out[k] = pads[k].pin_out;
    assign pad_oe[k] = pads[k].pin_oe;
  end
  assign port_pin_level = pad_sync_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Input merges toward peripherals
  ppfs_in_merge #(.N(2), .AND_TYPE(1'b1)) u_external_interrupt_0_in (.pin_val({external_interrupt_0_in_other_pins, pad_sync_reg[2]}),
    .pin_sel({1'b1, pb2_irq}), .merged(external_interrupt_0_in));
  ppfs_in_merge #(.N(2), .AND_TYPE(1'b1)) u_oe0 (.pin_val({oereq0_other_pins, pad_sync_reg[2]}),
    .pin_sel({1'b1, pb2_oe}), .merged(output_enable_request_0_in));
  ppfs_in_merge #(.N(2), .AND_TYPE(1'b0)) u_capw (.pin_val({capw_other_pins, pad_sync_reg[1]}),
    .pin_sel({1'b1, pb1_capw}), .merged(timer_capture_w_in));
  ppfs_in_merge #(.N(2), .AND_TYPE(1'b0)) u_capws (.pin_val({capws_other_pins, pad_sync_reg[0]}),
    .pin_sel({1'b1, pb0_capw}), .merged(secondary_timer_capture_w_in));
  ppfs_in_merge #(.N(2), .AND_TYPE(1'b0)) u_ch4d (.pin_val({ch4d_other_pins, pad_sync_reg[4]}),
    .pin_sel({1'b1, porte_line_21_tmr}), .merged(secondary_timer_ch4_d_in));
  ppfs_in_merge #(.N(2), .AND_TYPE(1'b0)) u_ch4c (.pin_val({ch4c_other_pins, pad_sync_reg[3]}),
    .pin_sel({1'b1, porte_line_20_tmr}), .merged(secondary_timer_ch4_c_in));

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Reserved bits can never be set by a write
  reserved_b_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    portb_ctrl_reg[7] == 1'b0 && portb_ctrl_reg[3] == 1'b0)
    else $error("port B reserved bit set");
  reserved_e_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    port_e_high_function_control_2_reg[15:6] == 10'h000
    && port_e_high_function_control_2_reg[3:2] == 2'h0)
    else $error("port E reserved bit set");
  // Register writes and reads on the bus
  sequence pe_write_s;
    psel & penable & pwrite & hit_pe;
  endsequence
  sequence pb_write_s;
    psel & penable & pwrite & hit_pb;
  endsequence
  sequence pb_read_s;
    (psel && !penable && !pwrite && hit_pb) ##1 (psel && penable);
  endsequence
  sequence pe_read_s;
    (psel && !penable && !pwrite && hit_pe) ##1 (psel && penable);
  endsequence
  pe_write_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    pe_write_s and strap_done_reg |=> port_e_high_function_control_2_reg[5:0]
    == ($past(pwdata[5:0]) & 6'h33))
    else $error("port E write lost");
  pb_write_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    pb_write_s and strap_done_reg |=> portb_ctrl_reg
    == ($past(pwdata[15:0]) & `PPFS_PORTB_WMASK))
    else $error("port B write lost");
  pb_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pb_read_s |-> prdata[31:11] == 21'h0 && prdata[7] == 1'b0 && prdata[3] == 1'b0)
    else $error("port B reserved bit read as one");
  pe_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pe_read_s |-> prdata[31:6] == 26'h0 && prdata[3:2] == 2'h0)
    else $error("port E reserved bit read as one");
  // Values right after reset
  strap_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strap_done_reg) |-> portb_ctrl_reg[4] == $past(ext_sync_reg[1])
    && portb_ctrl_reg[0] == $past(ext_sync_reg[1]) && portb_ctrl_reg[8] == 1'b0)
    else $error("mode strap reset value wrong");
  strap_reset_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strap_done_reg) |-> port_e_high_function_control_2_reg == 16'h0000
    && portb_ctrl_reg[10:8] == 3'h0)
    else $error("mode field not zero after reset");
  // Pin routing
  addr_needs_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    pad_oe[1] && pb1_code == 3'h1 |-> ext_ok)
    else $error("address output outside extension mode");
  addr17_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    pb1_code == `PPFS_PB_ADDR && ext_ok |-> pad_oe[1] && pad_out[1] == address_bit_17_out)
    else $error("address bit 17 not driven");
  addr16_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    pb0_code == `PPFS_PB_ADDR && ext_ok |-> pad_oe[0] && pad_out[0] == address_bit_16_out)
    else $error("address bit 16 not driven");
  pb2_irq_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    pb2_code == 3'h1 && !pad_sync_reg[2] |-> !external_interrupt_0_in && !pad_oe[2])
    else $error("interrupt input not routed");
  oereq_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    pb2_code == `PPFS_PB2_OEREQ && !pad_sync_reg[2]
    |-> !output_enable_request_0_in && !pad_oe[2])
    else $error("output-enable request input not routed");
  capw_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    pb1_code == 3'h3 && pad_sync_reg[1] |-> timer_capture_w_in && !pad_oe[1])
    else $error("capture W not routed");
  capws_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    pb0_code == 3'h3 && pad_sync_reg[0] |-> secondary_timer_capture_w_in)
    else $error("secondary capture W not routed");
  porte_line_20_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    porte_line_20_code == 2'h1 |-> pad_out[3] == secondary_timer_ch4_c_out
    && pad_oe[3] == secondary_timer_ch4_c_oe)
    else $error("channel 4 C drive wrong");
  porte_line_21_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    porte_line_21_code == `PPFS_PE_TIMER |-> pad_out[4] == secondary_timer_ch4_d_out
    && pad_oe[4] == secondary_timer_ch4_d_oe)
    else $error("channel 4 D drive wrong");
  port_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    porte_line_21_code == 2'h0 |-> pad_out[4] == port_data[4] && pad_oe[4] == port_dir[4])
    else $error("port drive wrong");
endmodule

/* sim/ppfs_board_model.sv */
// Board-side model of the five pads seen by the pin function block
`timescale 1ns/1ps
module ppfs_board_model (
  // Device side of the pads
  input wire logic [4:0] pad_out,
  input wire logic [4:0] pad_oe,
  // Board drivers
  input wire logic [4:0] board_val,
  input wire logic [4:0] board_en,
  // Resolved pin levels
  output logic [4:0] pad_in
);
  // Device drive wins, then the board, else a pull-up holds the line high
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (board_en[i]) begin
        pad_in[i] = board_val[i];
      end else begin
        pad_in[i] = 1'b1;
      end
    end
  end
endmodule

/* sim/tb_top.sv */
// Self-checking testbench of the pin function select block
`timescale 1ns/1ps
`include "ppfs_params.svh"
module tb_top;
  import ppfs_pkg::*;
  localparam logic [11:0] PB = `PPFS_OFS_PORTB_CTRL;
  localparam logic [11:0] PE = `PPFS_OFS_PORTE_CTRL2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rom_off, ext, a17, a16;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] pdat, pdir, pad_in, pad_out, pad_oe, lvl, bval, ben;
  logic [5:0] oth, mrg;
  logic d_out, d_oe, c_out, c_oe;
  int mismatches, tests_run;
  ppfs_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_ext_rom_off(rom_off), .mode_ext(ext), .port_data(pdat),
    .port_dir(pdir), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .port_pin_level(lvl), .address_bit_17_out(a17), .address_bit_16_out(a16),
    .external_interrupt_0_in_other_pins(oth[0]), .oereq0_other_pins(oth[1]), .capw_other_pins(oth[2]),
    .capws_other_pins(oth[3]), .ch4d_other_pins(oth[4]), .ch4c_other_pins(oth[5]),
    .external_interrupt_0_in(mrg[0]), .output_enable_request_0_in(mrg[1]),
    .timer_capture_w_in(mrg[2]), .secondary_timer_capture_w_in(mrg[3]),
    .secondary_timer_ch4_d_in(mrg[4]), .secondary_timer_ch4_c_in(mrg[5]),
    .secondary_timer_ch4_d_out(d_out), .secondary_timer_ch4_d_oe(d_oe),
    .secondary_timer_ch4_c_out(c_out), .secondary_timer_ch4_c_oe(c_oe));
  ppfs_board_model i_board (.pad_out(pad_out), .pad_oe(pad_oe), .board_val(bval),
    .board_en(ben), .pad_in(pad_in));
  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing report
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // APB master: setup, access until pready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(e, 0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 0, r, e);
    chk(r, x);
    chk(e, 0);
  endtask
  // Lets the pad and strap synchronisers settle, then samples mid-cycle
  task settle;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask
  // Input function: board drives the pin, other pins drive oth
  // Port direction is set to output, so only the function select keeps the pin undriven
  task in_chk(input int p, input int f, input logic v, input logic o, input logic x);
    @(posedge pclk);
    ben[p] <= 1'b1; bval[p] <= v; oth[f] <= o;
    pdir[p] <= 1'b1;
    settle();
    chk(pad_oe[p], 0);
    chk(mrg[f], x);
    chk(lvl[p], v);
  endtask
  // Port function: drive and direction come from the port registers
  task out_chk(input int p, input logic dr, input logic v);
    @(posedge pclk);
    pdir[p] <= dr; pdat[p] <= v;
    settle();
    chk(pad_oe[p], dr);
    if (dr) chk(pad_out[p], v);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_regs;
    logic [31:0] r;
    logic e;
    rd(PB, 0);
    rd(PE, 0);
    rd(12'h008, 0);
    wr(PB, 32'h0000_0888);
    wr(PE, 32'hFFFF_FFCC);
    rd(PB, 0);
    rd(PE, 0);
    apb(1'b1, 12'h00C, 32'h0000_0111, r, e);
    chk(e, 1);
    apb(1'b0, 12'h00C, 0, r, e);
    chk({r[0], e}, 2'h1);
    rd(PB, 0);
  endtask
  task t_pb2;
    for (int c = 1; c < 3; c++) begin
      wr(PB, c << 8);
      rd(PB, c << 8);
      in_chk(2, c - 1, 1'b1, 1'b1, 1'b1);
      in_chk(2, c - 1, 1'b1, 1'b0, 1'b0);
      in_chk(2, c - 1, 1'b0, 1'b1, 1'b0);
    end
    wr(PB, 0);
    out_chk(2, 1'b1, 1'b0);
    out_chk(2, 1'b0, 1'b1);
  endtask
  task t_pb10;
    wr(PB, 32'h33);
    rd(PB, 32'h33);
    in_chk(1, 2, 1'b1, 1'b0, 1'b1);
    in_chk(1, 2, 1'b0, 1'b0, 1'b0);
    in_chk(0, 3, 1'b1, 1'b0, 1'b1);
    in_chk(0, 3, 1'b0, 1'b1, 1'b1);
    wr(PB, 32'h11);
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      ext <= 1'b1; a17 <= !k[0]; a16 <= k[0];
      settle();
      chk({pad_oe[1:0], pad_out[1:0]}, {2'h3, !k[0], k[0]});
    end
    @(posedge pclk);
    ext <= 1'b0;
    settle();
    chk(pad_oe[1:0], 2'h0);
    wr(PB, 0);
    out_chk(1, 1'b1, 1'b1);
    out_chk(0, 1'b1, 1'b0);
  endtask
  task t_pe;
    wr(PE, 32'h11);
    rd(PE, 32'h11);
    @(posedge pclk);
    d_oe <= 1'b1; d_out <= 1'b1; c_oe <= 1'b1; c_out <= 1'b0;
    settle();
    chk({pad_oe[4:3], pad_out[4:3]}, 4'hE);
    @(posedge pclk);
    d_oe <= 1'b0; c_oe <= 1'b0;
    in_chk(4, 4, 1'b1, 1'b0, 1'b1);
    in_chk(3, 5, 1'b0, 1'b0, 1'b0);
    wr(PE, 0);
    out_chk(4, 1'b1, 1'b0);
    out_chk(3, 1'b1, 1'b1);
  endtask
  // Reset again in ROM-less extension mode: line 1 and 0 start as address outputs
  task t_rom;
    @(posedge pclk);
    presetn <= 1'b0; rom_off <= 1'b1; ben <= 5'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(PB, 32'h11);
    rd(12'h008, 32'h3);
    settle();
    chk(pad_oe[1:0], 2'h3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock, reset and main sequence
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    mismatches = 0; tests_run = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = '0; pwdata = '0; rom_off = 1'b0; ext = 1'b0; a17 = 1'b0;
    a16 = 1'b0; pdat = '0; pdir = '0; bval = '0; ben = '0; oth = '0;
    d_out = 1'b0; d_oe = 1'b0; c_out = 1'b0; c_oe = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_pb2();
    t_pb10();
    t_pe();
    t_rom();
    stop_test();
  end
endmodule
